//--- inc/power_mode_pkg.sv
/*
 * power_mode_pkg: register offset, field positions, reset values, start-up
 * timer constants and state encodings for the power mode wake controller.
 * assumes: sys_clk at 100 MHz; start-up times given in microseconds.
 */
package power_mode_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] PWR_CTRL_ADDR   = 8'h87;
    localparam logic [7:0] PWR_CTRL_RESET  = 8'h00;

    localparam int IDLE_BIT     = 0;
    localparam int PDOWN_BIT    = 1;
    localparam int SPARE_LO_BIT = 2;
    localparam int SPARE_HI_BIT = 3;
    localparam int COLD_BIT     = 4;
    localparam int WAKE_SEL_BIT = 5;
    localparam int FRAME_SEL_BIT = 6;
    localparam int BAUD_DBL_BIT = 7;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int SUT_MIN_US     = 16;
    localparam int SUT_MAX_US     = 16384;
    localparam int SUT_MIN_CYC    = SUT_MIN_US * CLK_MHZ;
    localparam int SUT_MAX_CYC    = SUT_MAX_US * CLK_MHZ;
    localparam int SUT_CNT_W      = 21;
    localparam int WARM_RST_CYC   = 2;

    // start-up time per fuse pair, internal RC / external clock (us)
    localparam int SUT_RC_US  [4] = '{16, 512, 1024, 4096};
    // start-up time per fuse pair, crystal oscillator (us)
    localparam int SUT_XTL_US [4] = '{1024, 2048, 4096, 16384};

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN      = 3'b000,
        ST_IDLE     = 3'b001,
        ST_PDOWN    = 3'b010,
        ST_WAKE_TMR = 3'b011,
        ST_WAKE_PIN = 3'b100,
        ST_RST_TMR  = 3'b101,
        ST_RST_HOLD = 3'b110,
        ST_RST_WARM = 3'b111
    } pm_state_t;

endpackage

//--- logic/startup_timer.sv
/*
 * startup_timer: loadable down counter for the oscillator start-up wait.
 * assumes: start pulses one cycle; count length chosen by the caller.
 */
`timescale 1ns/100ps
module startup_timer
    import power_mode_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 clkEn,
    // control
    input  wire logic                 start,
    input  wire logic [SUT_CNT_W-1:0] length,
    // status
    output logic                      running,
    output logic                      expired
);
    typedef struct packed {
        logic [SUT_CNT_W-1:0] cnt;
        logic                 run;
        logic                 done;
    } tmr_t;

    tmr_t tmr_q;
    tmr_t tmr_d;

    always_comb begin
        tmr_d = tmr_q;
        tmr_d.done = 1'b0;
        if (start) begin
            tmr_d.cnt = length;
            tmr_d.run = 1'b1;
        end else if (tmr_q.run) begin
            if (tmr_q.cnt <= SUT_CNT_W'(1)) begin
                tmr_d.run  = 1'b0;
                tmr_d.done = 1'b1;
                tmr_d.cnt  = '0;
            end else begin
                tmr_d.cnt = tmr_q.cnt - SUT_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tmr_q <= '0;
        end else if (clkEn) begin
            tmr_q <= tmr_d;
        end
    end

    assign running = tmr_q.run;
    assign expired = tmr_q.done;
endmodule // startup_timer

//--- logic/power_mode_wake_controller.sv
/*
 * power_mode_wake_controller: idle and power-down sequencing, wake-up
 * qualification, start-up timing and the power control register.
 * assumes: all pins synchronous to sys_clk; sys_rst is the warm reset;
 * coldRst marks a power-up reset; the core holds its own state while
 * its clock enable is low.
 */
// Implementation choice: strobed register access.
//
// Behaviour
// (RQ1) idle gates core clock, core keeps state
// (RQ2) idle freezes port pin drive levels
// (RQ3) timers, serial, spi, gpi clocked in idle
// (RQ4) comparator and watchdog idle run selectable
// (RQ5) enabled interrupt or reset ends idle
// (RQ6) power-down stops oscillator and flash
// (RQ7) power-down exits: reset, power-on, qualified interrupt
// (RQ8) int0/ext_irq_one_pin wake: enabled, level mode, not clock pin
// (RQ9) gp_irq_line_three wake: reset pin off, enabled, low level
// (RQ10) exit select 0: falling edge starts timer
// (RQ11) timer length from fuses; pin may rise
// (RQ12) exit select 1: core waits for pin rise
// (RQ13) far side holds pin low until stable
// (RQ14) reset pin fall wakes with start-up timer
// (RQ15) early reset release gives two-cycle reset
// (RQ16) bit 1 write starts power-down
// (RQ17) bit 0 write starts idle
// (RQ18) cold flag set by power-up only; a register write with bit 4 high also sets it
// (RQ19) start-up length from two fuses, clock type
// (RQ20) both bits: power-down; bits clear on exit
`timescale 1ns/100ps
module power_mode_wake_controller
    import power_mode_pkg::*;
(
    // clock, reset and clock enable
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       coldRst,
    input  wire logic       clkEn,
    // register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdData,
    // configuration fuses and options
    input  wire logic [1:0] sutFuse,
    input  wire logic       xtalSource,
    input  wire logic       resetPinEn,
    input  wire logic       clkUsesPinZero,
    input  wire logic       clkUsesPinOne,
    input  wire logic       cmpRunInIdle,
    input  wire logic       wdtRunInIdle,
    // interrupt configuration and requests
    input  wire logic       extIrqZeroEn,
    input  wire logic       extIrqZeroLevel,
    input  wire logic       extIrqOneEn,
    input  wire logic       extIrqOneLevel,
    input  wire logic       gpThreeEn,
    input  wire logic       gpThreeLowLevel,
    input  wire logic       anyIrqPending,
    // wake pins
    input  wire logic       extIrqZeroPin,
    input  wire logic       ext_irq_one_pin,
    input  wire logic       gp_irq_line_three,
    input  wire logic       resetPin_n,
    // port pins
    input  wire logic [7:0] portOutLive,
    output logic      [7:0] portOut,
    // clock, power and reset controls; serial mode bits
    output logic            cpuClkEn,
    output logic            periphClkEn,
    output logic            cmpClkEn,
    output logic            wdtClkEn,
    output logic            oscEn,
    output logic            flashPowerEn,
    output logic            coreRst,
    output logic            baudDoubler,
    output logic            frameErrorViewSelect
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        pm_state_t  st;
        logic [7:0] pwrCtrl;
        logic [7:0] portHold;
        logic [7:0] rdData;
        logic       wakePinPrev;
        logic       rstPinPrev;
        logic       rstSeenHigh;
        logic [1:0] warmCnt;
    } pm_t;

    pm_t pm_q;
    pm_t pm_d;

    logic                 tmrStart;
    logic [SUT_CNT_W-1:0] tmrLength;
    logic                 tmrRunning;
    logic                 tmrExpired;
    logic                 wakeZero;
    logic                 wakeOne;
    logic                 wakeThree;
    logic                 wakeLevel;
    logic                 wakeFall;
    logic                 rstFall;
    int                   sutUs;

    // ------------------------------------------------------------------
    // wake qualification
    // ------------------------------------------------------------------
    // level mode only: edge flags need a running clock to latch
    assign wakeZero  = extIrqZeroEn & extIrqZeroLevel & ~clkUsesPinZero; // [RQ8]
    assign wakeOne   = extIrqOneEn & extIrqOneLevel & ~clkUsesPinOne; // [RQ8]
    assign wakeThree = ~resetPinEn & gpThreeEn & gpThreeLowLevel; // [RQ9]
    assign wakeLevel = ~((wakeZero & ~extIrqZeroPin) | (wakeOne & ~ext_irq_one_pin)
                       | (wakeThree & ~gp_irq_line_three));
    assign wakeFall  = pm_q.wakePinPrev & ~wakeLevel;
    assign rstFall   = resetPinEn & pm_q.rstPinPrev & ~resetPin_n;

    // ------------------------------------------------------------------
    // start-up length
    // ------------------------------------------------------------------
    always_comb begin
        sutUs = xtalSource ? SUT_XTL_US[sutFuse] : SUT_RC_US[sutFuse]; // [RQ19]
        tmrLength = SUT_CNT_W'(sutUs * CLK_MHZ); // [RQ11]
    end

    startup_timer u_sut (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .start   (tmrStart),
        .length  (tmrLength),
        .running (tmrRunning),
        .expired (tmrExpired)
    );

    // ------------------------------------------------------------------
    // sequencer and register
    // ------------------------------------------------------------------
    always_comb begin
        pm_d = pm_q;
        tmrStart = 1'b0;
        pm_d.wakePinPrev = wakeLevel;
        pm_d.rstPinPrev  = resetPin_n;
        pm_d.rdData = (regRead && regAddr == PWR_CTRL_ADDR) ? pm_q.pwrCtrl : 8'h00;
        if (regWrite && regAddr == PWR_CTRL_ADDR) begin
            pm_d.pwrCtrl = regWrData; // [RQ18]
        end
        case (pm_q.st)
            ST_RUN: begin
                pm_d.portHold = portOutLive;
                // decode the value being written so entry follows the strobe directly
                if (pm_d.pwrCtrl[PDOWN_BIT]) begin
                    pm_d.st = ST_PDOWN; // [RQ16] [RQ20]
                end else if (pm_d.pwrCtrl[IDLE_BIT]) begin
                    pm_d.st = ST_IDLE; // [RQ17]
                end
            end
            ST_IDLE: begin
                if (anyIrqPending) begin
                    pm_d.st = ST_RUN; // [RQ5]
                    pm_d.pwrCtrl[IDLE_BIT] = 1'b0; // [RQ20]
                end
            end
            ST_PDOWN: begin
                if (rstFall) begin
                    pm_d.st = ST_RST_TMR; // [RQ14]
                    pm_d.rstSeenHigh = 1'b0;
                    // stale request bits would drop straight back into power-down
                    pm_d.pwrCtrl[PDOWN_BIT] = 1'b0;
                    pm_d.pwrCtrl[IDLE_BIT]  = 1'b0; // [RQ20]
                    tmrStart = 1'b1;
                end else if (wakeFall) begin
                    if (pm_q.pwrCtrl[WAKE_SEL_BIT]) begin
                        pm_d.st = ST_WAKE_PIN; // [RQ12]
                    end else begin
                        pm_d.st = ST_WAKE_TMR; // [RQ10]
                        tmrStart = 1'b1;
                    end
                end
            end
            ST_WAKE_TMR: begin
                // pin level no longer matters once timing began
                if (tmrExpired) begin
                    pm_d.st = ST_RUN; // [RQ11]
                    pm_d.pwrCtrl[PDOWN_BIT] = 1'b0;
                    pm_d.pwrCtrl[IDLE_BIT]  = 1'b0; // [RQ20]
                end
            end
            ST_WAKE_PIN: begin
                // relies on the source holding low past oscillator settle
                if (wakeLevel) begin
                    pm_d.st = ST_RUN; // [RQ12] [RQ13]
                    pm_d.pwrCtrl[PDOWN_BIT] = 1'b0;
                    pm_d.pwrCtrl[IDLE_BIT]  = 1'b0; // [RQ20]
                end
            end
            ST_RST_TMR: begin
                if (resetPin_n) begin
                    pm_d.rstSeenHigh = 1'b1;
                end
                if (tmrExpired) begin
                    if (pm_q.rstSeenHigh || resetPin_n) begin
                        pm_d.st = ST_RST_WARM; // [RQ15]
                        pm_d.warmCnt = 2'(WARM_RST_CYC - 1);
                    end else begin
                        pm_d.st = ST_RST_HOLD; // [RQ15]
                    end
                end
            end
            ST_RST_HOLD: begin
                if (resetPin_n) begin
                    pm_d.st = ST_RUN; // [RQ15]
                end
            end
            ST_RST_WARM: begin
                if (pm_q.warmCnt == 2'd0) begin
                    pm_d.st = ST_RUN;
                end else begin
                    pm_d.warmCnt = pm_q.warmCnt - 2'd1;
                end
            end
            default: begin
                pm_d.st = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pm_q <= '{st: ST_RUN, pwrCtrl: PWR_CTRL_RESET, portHold: 8'h00,
                      rdData: 8'h00, wakePinPrev: 1'b1, rstPinPrev: 1'b1,
                      rstSeenHigh: 1'b0, warmCnt: 2'd0};
        end else if (clkEn) begin
            pm_q <= pm_d;
            // warm reset clears cold flag; power-up sets it
            if (coldRst) begin
                pm_q.pwrCtrl[COLD_BIT] <= 1'b1; // [RQ18]
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic asleep;
    assign asleep       = pm_q.st != ST_RUN;
    assign cpuClkEn     = ~asleep; // [RQ1] [RQ5]
    assign portOut      = asleep ? pm_q.portHold : portOutLive; // [RQ2]
    assign periphClkEn  = pm_q.st != ST_PDOWN; // [RQ3]
    assign cmpClkEn     = (pm_q.st == ST_RUN) | ((pm_q.st == ST_IDLE) & cmpRunInIdle); // [RQ4]
    assign wdtClkEn     = (pm_q.st == ST_RUN) | ((pm_q.st == ST_IDLE) & wdtRunInIdle); // [RQ4]
    assign oscEn        = pm_q.st != ST_PDOWN; // [RQ6] [RQ7]
    assign flashPowerEn = pm_q.st != ST_PDOWN; // [RQ6]
    assign coreRst      = (pm_q.st == ST_RST_WARM) | (pm_q.st == ST_RST_HOLD); // [RQ15]
    assign regRdData    = pm_q.rdData;
    assign baudDoubler  = pm_q.pwrCtrl[BAUD_DBL_BIT];
    assign frameErrorViewSelect = pm_q.pwrCtrl[FRAME_SEL_BIT];
endmodule // power_mode_wake_controller

//--- tb/wake_side_model.sv
/*
 * wake_side_model: core port drive and the wake and reset pins.
 * assumes: pins idle high; pulses are commanded by the bench.
 */
`timescale 1ns/100ps
module wake_side_model (
    // clock
    input  wire logic        sys_clk,
    // core side
    input  wire logic        cpuClkEn,
    output logic      [7:0]  portOutLive,
    // pulse request
    input  wire logic [1:0]  pinSel,
    input  wire logic        pulseGo,
    input  wire logic [15:0] pulseLen,
    // pins
    output logic             extIrqZeroPin,
    output logic             ext_irq_one_pin,
    output logic             gp_irq_line_three,
    output logic             resetPin_n
);
    integer      seed = 46234;
    logic [15:0] cnt  = 16'h0000;
    logic [3:0]  low  = 4'h0;

    initial portOutLive = 8'h00;

    always @(posedge sys_clk) begin
        // core only moves while clocked, so held pins stay meaningful
        if (cpuClkEn)
            portOutLive <= 8'($random(seed));
        if (pulseGo) begin
            low <= 4'h1 << pinSel;
            cnt <= pulseLen;
        end else if (cnt != 16'h0000)
            cnt <= cnt - 16'h0001;
        else
            low <= 4'h0;
    end

    // pins rest high; low for the whole commanded span
    assign {resetPin_n, gp_irq_line_three, ext_irq_one_pin, extIrqZeroPin} = ~low;
endmodule // wake_side_model

//--- tb/power_mode_checker_assertions.sv
/*
 * power_mode_checker: mode entry, exit and port hold properties.
 * assumes: bound to the controller; one clock, synchronous reset.
 */
`timescale 1ns/100ps
module power_mode_checker
    import power_mode_pkg::*;
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       clkEn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    // options and pins
    input wire logic       cmpRunInIdle,
    input wire logic       wdtRunInIdle,
    input wire logic       anyIrqPending,
    input wire logic       extIrqZeroPin,
    input wire logic       ext_irq_one_pin,
    input wire logic       gp_irq_line_three,
    input wire logic       resetPin_n,
    input wire logic [7:0] portOutLive,
    // outputs
    input wire logic [7:0] portOut,
    input wire logic       cpuClkEn,
    input wire logic       periphClkEn,
    input wire logic       cmpClkEn,
    input wire logic       wdtClkEn,
    input wire logic       oscEn,
    input wire logic       flashPowerEn,
    input wire logic       coreRst
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    wire run   = cpuClkEn && oscEn && !coreRst;
    wire ctlWr = regWrite && clkEn && regAddr == PWR_CTRL_ADDR && run;
    wire idlWr = ctlWr && regWrData[1:0] == 2'b01;

    AST_IDLE_ENTRY: assert property (idlWr |=>
        !cpuClkEn && periphClkEn && oscEn) else $error("idle entry wrong");
    AST_PDOWN_ENTRY: assert property (ctlWr && regWrData[1] |=>
        !oscEn && !flashPowerEn && !cpuClkEn) else $error("power-down entry wrong");
    AST_CMP_IDLE: assert property (idlWr |=> cmpClkEn == $past(cmpRunInIdle))
        else $error("comparator idle clock wrong");
    AST_WDT_IDLE: assert property (idlWr |=> wdtClkEn == $past(wdtRunInIdle))
        else $error("watchdog idle clock wrong");
    AST_PORT_HOLD: assert property (!cpuClkEn && !$past(cpuClkEn) |-> $stable(portOut))
        else $error("port moved while core stopped");
    AST_PORT_LIVE: assert property (run |-> portOut == portOutLive)
        else $error("port not live in run");
    AST_IDLE_EXIT: assert property (
        !cpuClkEn && oscEn && periphClkEn && !coreRst && anyIrqPending && clkEn
        |-> ##[1:2] cpuClkEn) else $error("idle not left on interrupt");
    AST_PDOWN_STAY: assert property (!oscEn && extIrqZeroPin && ext_irq_one_pin &&
        gp_irq_line_three && resetPin_n |=> !oscEn) else $error("power-down left alone");
    AST_WARM_RST: assert property ($rose(coreRst) && resetPin_n |->
        ##1 coreRst ##1 !coreRst) else $error("short reset not two cycles");
    AST_RST_HOLD: assert property (coreRst && !resetPin_n |=> coreRst)
        else $error("reset released while pin low");
endmodule // power_mode_checker

bind power_mode_wake_controller power_mode_checker u_chk (.sys_clk, .sys_rst, .clkEn,
    .regAddr, .regWrData, .regWrite, .cmpRunInIdle, .wdtRunInIdle, .anyIrqPending,
    .extIrqZeroPin, .ext_irq_one_pin, .gp_irq_line_three, .resetPin_n, .portOutLive,
    .portOut, .cpuClkEn, .periphClkEn, .cmpClkEn, .wdtClkEn, .oscEn, .flashPowerEn,
    .coreRst);

//--- tb/power_mode_wake_controller_tb_top.sv
/*
 * testbench: register, idle and power-down wake sequences.
 * assumes: shortest start-up setting, 1600 cycles at 100 MHz.
 */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module power_mode_wake_controller_tb_top;
    import power_mode_pkg::*;
    logic sys_clk, sys_rst, coldRst, clkEn, regWrite, regRead, xtalSource, resetPinEn;
    logic clkUsesPinZero, clkUsesPinOne, cmpRunInIdle, wdtRunInIdle, extIrqZeroEn;
    logic extIrqZeroLevel, extIrqOneEn, extIrqOneLevel, gpThreeEn, gpThreeLowLevel;
    logic anyIrqPending, extIrqZeroPin, ext_irq_one_pin, gp_irq_line_three, resetPin_n;
    logic cpuClkEn, periphClkEn, cmpClkEn, wdtClkEn, oscEn, flashPowerEn, coreRst;
    logic baudDoubler, frameErrorViewSelect, pulseGo, rdPend;
    logic [7:0]  regAddr, regWrData, regRdData, portOutLive, portOut, rdExp, held;
    logic [1:0]  sutFuse, pinSel;
    logic [15:0] pulseLen;
    logic [7:0]  expQ[$];
    int          n_errors = 0, tests_run = 0, n, h;

    power_mode_wake_controller DUT (.*);
    wake_side_model u_far (.*);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // read data stands only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (rdPend) begin
            rdExp = expQ.pop_front();
            `CHK("regRdData", rdExp, regRdData)
        end
        rdPend <= regRead;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
    endtask
    task automatic pulse(input logic [1:0] p, input int len);
        pinSel <= p;
        pulseLen <= len[15:0];
        pulseGo <= 1'b1;
        @(posedge sys_clk);
        pulseGo <= 1'b0;
    endtask
    task automatic waitRun(input int lim);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (cpuClkEn !== 1'b1 && n < lim);
        @(posedge sys_clk);
    endtask
    task automatic enterPd(input logic [7:0] ctl);
        wr(PWR_CTRL_ADDR, ctl);
        @(negedge sys_clk);
        `CHK("osc flash", 2'b00, {oscEn, flashPowerEn})
        @(posedge sys_clk);
    endtask
    task automatic wake(input logic [1:0] p, input int len, input int lo, input int hi);
        pulse(p, len);
        waitRun(hi + 4);
        `CHK("wake span", 1'b1, n >= lo && n <= hi)
    endtask
    task automatic rstWake(input int len);
        pulse(2'd3, len);
        n = 0;
        while (coreRst !== 1'b1 && n < 5000) begin
            @(negedge sys_clk);
            n++;
        end
        h = 0;
        while (coreRst === 1'b1 && h < 5000) begin
            @(negedge sys_clk);
            h++;
        end
        `CHK("reset wake", 1'b1, n >= 1600)
        @(posedge sys_clk);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        {coldRst, regWrite, regRead, xtalSource, clkUsesPinZero, clkUsesPinOne,
         cmpRunInIdle, wdtRunInIdle, extIrqZeroEn, extIrqZeroLevel, extIrqOneEn,
         extIrqOneLevel, gpThreeEn, gpThreeLowLevel, anyIrqPending, pulseGo, rdPend,
         resetPinEn, regAddr, regWrData, sutFuse, pinSel, pulseLen} = '0;
        clkEn = 1'b1;
        sys_rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        coldRst <= 1'b1;
        @(posedge sys_clk);
        coldRst <= 1'b0;
        rd(PWR_CTRL_ADDR, 8'h10);
        wr(8'h86, 8'hFF);
        rd(8'h86, 8'h00);
        rd(PWR_CTRL_ADDR, 8'h10);
        wr(PWR_CTRL_ADDR, 8'hDC);
        rd(PWR_CTRL_ADDR, 8'hDC);
        @(negedge sys_clk);
        `CHK("uart bits", 2'b11, {baudDoubler, frameErrorViewSelect})
        @(posedge sys_clk);
        // frozen clock enable must drop the write
        clkEn <= 1'b0;
        wr(PWR_CTRL_ADDR, 8'h01);
        clkEn <= 1'b1;
        rd(PWR_CTRL_ADDR, 8'hDC);
        @(negedge sys_clk);
        `CHK("frozen idle", 1'b1, cpuClkEn)
        @(posedge sys_clk);
        for (int i = 0; i < 2; i++) begin
            cmpRunInIdle <= i[0];
            wdtRunInIdle <= !i[0];
            wr(PWR_CTRL_ADDR, 8'h01);
            @(negedge sys_clk);
            held = portOut;
            `CHK("core clock", 1'b0, cpuClkEn)
            `CHK("periph clock", 1'b1, periphClkEn)
            `CHK("cmp wdt", {i[0], !i[0]}, {cmpClkEn, wdtClkEn})
            repeat (5) @(negedge sys_clk);
            `CHK("portOut", held, portOut)
            @(posedge sys_clk);
            anyIrqPending <= 1'b1;
            waitRun(4);
            anyIrqPending <= 1'b0;
            `CHK("idle exit", 1'b1, n < 4)
            rd(PWR_CTRL_ADDR, 8'h00);
        end
        enterPd(8'h03);
        pulse(2'd0, 4);
        repeat (40) @(posedge sys_clk);
        `CHK("edge mode wake", 1'b0, oscEn)
        extIrqZeroEn <= 1'b1;
        extIrqZeroLevel <= 1'b1;
        wake(2'd0, 4, 1600, 1610);
        rd(PWR_CTRL_ADDR, 8'h00);
        extIrqOneEn <= 1'b1;
        extIrqOneLevel <= 1'b1;
        enterPd(8'h22);
        wake(2'd1, 2000, 2000, 2006);
        rd(PWR_CTRL_ADDR, 8'h20);
        gpThreeEn <= 1'b1;
        gpThreeLowLevel <= 1'b1;
        enterPd(8'h02);
        wake(2'd2, 4, 1600, 1610);
        resetPinEn <= 1'b1;
        enterPd(8'h02);
        rstWake(4);
        `CHK("short reset", 1'b1, h == 2)
        enterPd(8'h02);
        rstWake(3000);
        `CHK("held reset", 1'b1, h >= 1390 && h <= 1410)
        conclude();
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        n_errors++;
        conclude();
    end
endmodule // power_mode_wake_controller_tb_top
